// ---- pkg/fcr_pkg.sv ----
package fcr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and program/erase pulse timing
    localparam int CORE_CLK_HZ    = 50_000_000;
    localparam int CORE_CLK_MHZ   = CORE_CLK_HZ / 1_000_000;
    localparam int PULSE_MIN_NS   = 5000;   // 5 us shortest timing pulse
    localparam int PULSE_MAX_NS   = 6700;   // 6.7 us longest timing pulse
    // Least time rounds up, longest time rounds down
    localparam int PULSE_MIN_CYC  = (PULSE_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int PULSE_MAX_CYC  = (PULSE_MAX_NS * CORE_CLK_MHZ) / 1000;
    localparam int PRESCALE_RATIO = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CLK_RATIO = 8'h00;
    localparam logic [7:0] OFF_OPTION    = 8'h04;
    localparam logic [7:0] OFF_KEY_CTRL  = 8'h08;
    localparam logic [7:0] OFF_KEY_DATA  = 8'h0c;
    localparam logic [7:0] OFF_STATUS    = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CR_LOADED_BIT   = 7;
    localparam int CR_PRESCALE_BIT = 6;
    localparam int CR_RATIO_LSB    = 0;
    localparam int CR_RATIO_W      = 6;
    localparam int OPT_KEY_EN_BIT  = 7;
    localparam int OPT_NORED_BIT   = 6;
    localparam int OPT_SEC_LSB     = 0;
    localparam int OPT_SEC_W       = 2;
    localparam int KC_ACCESS_BIT   = 0;
    localparam int ST_SECURE_BIT   = 0;
    localparam int ST_PE_EN_BIT    = 1;
    localparam int ST_RANGE_BIT    = 2;
    localparam int ST_KEY_BUSY_BIT = 3;
    localparam int ST_PE_BUSY_BIT  = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Codes, sizes and reset values
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam int         KEY_BYTES     = 8;
    localparam logic [5:0] RATIO_RESET   = 6'h00;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ENTRY,
        KEY_CHECK
    } fcr_key_state_t;

endpackage : fcr_pkg

// ---- src/fcr_clk_div.sv ----
module fcr_clk_div #(
    parameter int RATIO_W  = 6,
    parameter int PRESCALE = 8
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Divider setting
    input  wire logic               enable,
    input  wire logic               prescale,
    input  wire logic [RATIO_W-1:0] ratio,
    // One-cycle flash timing enable
    output logic                    tick
);
    import fcr_pkg::*;

    localparam int PW = $clog2(PRESCALE);

    ////////////////////////////////////////////////////////////////////////////////
    // Prescale counter wraps freely, so it must be a power of two
    if (PRESCALE < 2 || (1 << PW) != PRESCALE) begin : g_bad_pre
        $error("fcr_clk_div: PRESCALE must be a power of two");
    end

    typedef struct packed {
        logic [PW-1:0]      preCnt;
        logic [RATIO_W-1:0] divCnt;
        logic               tick;
    } fcr_div_state_t;

    fcr_div_state_t s;
    fcr_div_state_t next_s;
    logic           preTick;

    // Prescaler then divide by ratio plus one
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        preTick     = !prescale || (s.preCnt == PW'(PRESCALE - 1));
        if (!enable) begin
            next_s.preCnt = '0;
            next_s.divCnt = '0;
        end else begin
            next_s.preCnt = prescale ? s.preCnt + PW'(1) : '0;
            if (preTick) begin
                if (s.divCnt == ratio) begin
                    next_s.divCnt = '0;
                    next_s.tick   = 1'b1;
                end else begin
                    next_s.divCnt = s.divCnt + RATIO_W'(1);
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule // fcr_clk_div

// ---- src/fcr_flash_cfg.sv ----
// Overview of operation
// - Ratio top bit read-only, low seven write-once
// - Loaded flag clears on reset, sets first write
// - Program/erase refused until ratio is loaded
// - Prescale bit selects bus clock or divide-by-eight
// - Divider divides input by field plus one
// - Timing pulse is one flash clock cycle
// - Nonvolatile bytes copied into control registers at reset
// - Option register loaded from stored option byte
// - Option bits five to two zero, writes ignored
// - Key enable zero blocks backdoor unlocking
// - Key writes only from secured firmware, not debug
// - Matching eight-byte key unlocks until next reset
// - Redirect-disable one stops vector redirection
// - Codes 00 and 11 secure, 10 unsecured
// - Secure state blocks unsecured memory access
// - Key match or blank check sets code 10
// - Code 01 is secure as well
// - Blocked writes ignored, blocked reads return zero
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
module fcr_flash_cfg (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Source of the current bus access
    input  wire logic        busFromSecureFw,
    input  wire logic        busFromDebug,
    // Nonvolatile contents
    input  wire logic [7:0]  storedOptionByte,
    input  wire logic [63:0] storedBackdoorKey,
    // Program/erase sequencing
    input  wire logic        peRequest,
    input  wire logic [7:0]  peOpPulses,
    input  wire logic        blankCheckPass,
    output logic             progEraseEnable,
    output logic             peRefused,
    output logic             peBusy,
    output logic             peDone,
    output logic             timingPulse,
    // Security and vectors
    output logic             secureActive,
    output logic             redirectEnable,
    // Secure memory gate
    input  wire logic        memRead,
    input  wire logic        memWrite,
    input  wire logic        memFromUnsecured,
    input  wire logic [7:0]  memReadDataIn,
    output logic             memWriteEnable,
    output logic      [7:0]  memReadData
);
    import fcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    typedef struct packed {
        logic                  waitReq;
        logic [31:0]           rdata;
        logic                  loaded;
        logic                  prescale;
        logic [CR_RATIO_W-1:0] ratio;
        logic                  inRange;
        logic                  backdoor_key_enable;
        logic                  noRed;
        logic [OPT_SEC_W-1:0]  code;
        logic                  secure;
        logic                  redirEn;
        logic                  keyAccess;
        fcr_key_state_t        keyState;
        logic [3:0]            keyCount;
        logic [3:0]            chkIdx;
        logic                  cmpValid;
        logic [2:0]            cmpIdx;
        logic                  mismatch;
        logic                  peBusy;
        logic [7:0]            peLeft;
        logic                  peDone;
        logic                  peRefused;
        logic                  memWe;
        logic [7:0]            memRdata;
    } fcr_state_t;

    fcr_state_t s;
    fcr_state_t next_s;

    logic       flashTick;
    logic       kmWe;
    logic [2:0] kmWrAddr;
    logic [7:0] kmWrData;
    logic [2:0] kmRdAddr;
    logic [7:0] kmRdData;
    logic [4:0] sel;
    logic       busWrite;
    logic       keyWriteOk;
    logic [7:0] rdByte;
    logic [9:0] period;
    logic       byteBad;
    logic       blocked;

    // One-hot register select, shared by the read and write paths
    function automatic logic [4:0] decodeAddr(input logic [7:0] a);
        logic [4:0] r;
        r = 5'h00;
        if (a == OFF_CLK_RATIO) begin
            r = 5'h01;
        end else if (a == OFF_OPTION) begin
            r = 5'h02;
        end else if (a == OFF_KEY_CTRL) begin
            r = 5'h04;
        end else if (a == OFF_KEY_DATA) begin
            r = 5'h08;
        end else if (a == OFF_STATUS) begin
            r = 5'h10;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Flash timing clock divider, held idle until the ratio is loaded
    fcr_clk_div #(
        .RATIO_W  (CR_RATIO_W),
        .PRESCALE (PRESCALE_RATIO)
    ) u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .enable   (s.loaded),
        .prescale (s.prescale),
        .ratio    (s.ratio),
        .tick     (flashTick)
    );

    // Entered backdoor key bytes
    fcr_key_mem #(
        .WIDTH  (8),
        .DEPTH  (KEY_BYTES),
        .AW     (3)
    ) u_key (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wrEn     (kmWe),
        .wrAddr   (kmWrAddr),
        .wrData   (kmWrData),
        .rdAddr   (kmRdAddr),
        .rdData   (kmRdData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_s          = s;
        next_s.peDone   = 1'b0;
        next_s.peRefused = 1'b0;
        next_s.waitReq  = 1'b1;
        sel             = decodeAddr(avs_address);
        kmWe            = 1'b0;
        kmWrAddr        = s.keyCount[2:0];
        kmWrData        = avs_writedata[7:0];
        kmRdAddr        = s.chkIdx[2:0];
        byteBad         = 1'b0;
        // Write takes effect at the edge after the wait state, while waitrequest is low
        busWrite        = avs_write && !s.waitReq && avs_byteenable[0];
        // Debug commands never feed the key path
        keyWriteOk      = busWrite && busFromSecureFw && !busFromDebug && s.backdoor_key_enable;

        // Read mux; unmapped and write-only addresses read zero
        rdByte = 8'h00;
        if (sel[0]) begin
            rdByte = {s.loaded, s.prescale, s.ratio};
        end else if (sel[1]) begin
            rdByte = {s.backdoor_key_enable, s.noRed, 4'h0, s.code};
        end else if (sel[2]) begin
            rdByte = {7'h00, s.keyAccess};
        end else if (sel[4]) begin
            rdByte                  = 8'h00;
            rdByte[ST_SECURE_BIT]   = s.secure;
            rdByte[ST_PE_EN_BIT]    = s.loaded;
            rdByte[ST_RANGE_BIT]    = s.inRange;
            rdByte[ST_KEY_BUSY_BIT] = s.keyState != KEY_IDLE;
            rdByte[ST_PE_BUSY_BIT]  = s.peBusy;
        end

        // One wait state: answer one cycle after the request is seen
        if ((avs_read || avs_write) && s.waitReq) begin
            next_s.waitReq = 1'b0;
            next_s.rdata   = {24'h000000, rdByte};
        end

        // Ratio accepts only the first write after reset, any value
        if (busWrite && sel[0] && !s.loaded) begin
            next_s.loaded   = 1'b1;
            next_s.prescale = avs_writedata[CR_PRESCALE_BIT];
            next_s.ratio    = avs_writedata[CR_RATIO_LSB +: CR_RATIO_W];
        end
        // Option register writes fall through with no effect

        // Flags a legal pulse length for the chosen setting
        period = (s.prescale ? 10'(PRESCALE_RATIO) : 10'h001) * (10'(s.ratio) + 10'h001);
        next_s.inRange = (period >= 10'(PULSE_MIN_CYC)) && (period <= 10'(PULSE_MAX_CYC));

        // Key access open/close
        if (keyWriteOk && sel[2]) begin
            if (avs_writedata[KC_ACCESS_BIT] && !s.keyAccess && s.keyState == KEY_IDLE) begin
                next_s.keyAccess = 1'b1;
                next_s.keyCount  = 4'h0;
                next_s.keyState  = KEY_ENTRY;
            end else if (!avs_writedata[KC_ACCESS_BIT] && s.keyAccess) begin
                next_s.keyAccess = 1'b0;
                next_s.chkIdx    = 4'h0;
                next_s.cmpValid  = 1'b0;
                next_s.mismatch  = 1'b0;
                // A short key never matches
                next_s.keyState  = (s.keyCount == 4'(KEY_BYTES)) ? KEY_CHECK : KEY_IDLE;
            end
        end

        // Key bytes are taken in order; extras past eight are dropped
        if (keyWriteOk && sel[3] && s.keyAccess && s.keyCount < 4'(KEY_BYTES)) begin
            kmWe            = 1'b1;
            next_s.keyCount = s.keyCount + 4'h1;
        end

        // Compare walks the entered bytes against the stored key
        if (s.keyState == KEY_CHECK) begin
            if (s.chkIdx < 4'(KEY_BYTES)) begin
                next_s.chkIdx   = s.chkIdx + 4'h1;
                next_s.cmpValid = 1'b1;
                next_s.cmpIdx   = s.chkIdx[2:0];
            end else begin
                next_s.cmpValid = 1'b0;
            end
            if (s.cmpValid) begin
                byteBad         = kmRdData != storedBackdoorKey[{s.cmpIdx, 3'b000} +: 8];
                next_s.mismatch = s.mismatch || byteBad;
                if (s.cmpIdx == 3'(KEY_BYTES - 1)) begin
                    next_s.keyState = KEY_IDLE;
                    next_s.cmpValid = 1'b0;
                    if (!s.mismatch && !byteBad && s.backdoor_key_enable) begin
                        next_s.code = SEC_UNSECURED;
                    end
                end
            end
        end

        // Successful blank check also unlocks until reset
        if (blankCheckPass) begin
            next_s.code = SEC_UNSECURED;
        end

        // Only code 10 leaves the part unsecured
        next_s.secure  = next_s.code != SEC_UNSECURED;
        next_s.redirEn = !next_s.noRed;

        // Program/erase: refused before the ratio is loaded
        if (peRequest && !s.loaded) begin
            next_s.peRefused = 1'b1;
        end else if (peRequest && !s.peBusy) begin
            next_s.peBusy = 1'b1;
            next_s.peLeft = (peOpPulses == 8'h00) ? 8'h01 : peOpPulses;
        end
        // Operation lasts a whole number of timing pulses
        if (s.peBusy && flashTick) begin
            next_s.peLeft = s.peLeft - 8'h01;
            if (s.peLeft == 8'h01) begin
                next_s.peBusy = 1'b0;
                next_s.peDone = 1'b1;
            end
        end

        // Secure memory gate; flash reads also blank while key access is open
        blocked         = s.secure && memFromUnsecured;
        next_s.memWe    = memWrite && !blocked;
        next_s.memRdata = (memRead && !blocked && !s.keyAccess) ? memReadDataIn : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; reset copies the stored option byte into the shadow
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s          <= '0;
            s.waitReq  <= 1'b1;
            s.ratio    <= RATIO_RESET;
            s.loaded   <= 1'b0;
            s.keyState <= KEY_IDLE;
            s.backdoor_key_enable    <= storedOptionByte[OPT_KEY_EN_BIT];
            s.noRed    <= storedOptionByte[OPT_NORED_BIT];
            s.code     <= storedOptionByte[OPT_SEC_LSB +: OPT_SEC_W];
            s.secure   <= storedOptionByte[OPT_SEC_LSB +: OPT_SEC_W] != SEC_UNSECURED;
            s.redirEn  <= !storedOptionByte[OPT_NORED_BIT];
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.waitReq;
    assign progEraseEnable = s.loaded;
    assign peRefused       = s.peRefused;
    assign peBusy          = s.peBusy;
    assign peDone          = s.peDone;
    assign timingPulse     = flashTick;
    assign secureActive    = s.secure;
    assign redirectEnable  = s.redirEn;
    assign memWriteEnable  = s.memWe;
    assign memReadData     = s.memRdata;

endmodule // fcr_flash_cfg

// ---- src/fcr_key_mem.sv ----
module fcr_key_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Write port
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    // Registered read port
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);
    import fcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Refuse shapes the address cannot reach
    if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_bad_depth
        $error("fcr_key_mem: DEPTH does not fit AW");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } fcr_mem_state_t;

    fcr_mem_state_t s;
    fcr_mem_state_t next_s;

    // Read data lag the address by one cycle
    always_comb begin
        next_s    = s;
        next_s.rd = s.mem[rdAddr];
        if (wrEn) begin
            next_s.mem[wrAddr] = wrData;
        end
    end

    // Entered key is wiped on reset so a stale guess never survives
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdData = s.rd;

endmodule // fcr_key_mem

// ---- verification/fcr_flash_cfg_properties.sv ----
module fcr_props (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Register bus answer
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Nonvolatile option byte
    input wire logic [7:0]  storedOptionByte,
    // Program/erase sequencing
    input wire logic        peRequest,
    input wire logic        progEraseEnable,
    input wire logic        peRefused,
    input wire logic        peBusy,
    input wire logic        peDone,
    input wire logic        timingPulse,
    // Security and memory gate
    input wire logic        secureActive,
    input wire logic        redirectEnable,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic        memFromUnsecured,
    input wire logic        memWriteEnable,
    input wire logic [7:0]  memReadData
);
    timeunit 1ns;
    timeprecision 1ps;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("wait low too long");
    a_byte_wide_read: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper bytes set");

    ////////////////////////////////////////////////////////////////////////////////
    // Ratio gate on program/erase
    a_loaded_sticky: assert property (progEraseEnable |=> progEraseEnable)
        else $error("loaded flag cleared");
    a_refuse_unloaded: assert property (peRequest && !progEraseEnable |=> peRefused && !peBusy)
        else $error("early request not refused");
    a_idle_unloaded: assert property (!progEraseEnable |-> !timingPulse && !peBusy)
        else $error("timing before load");
    a_done_ends_busy: assert property (peDone |-> !peBusy && $past(peBusy))
        else $error("done not at busy end");

    ////////////////////////////////////////////////////////////////////////////////
    // Option load at reset and security
    a_opt_redirect: assert property ($rose(rst_n) |-> redirectEnable == !$past(storedOptionByte[6]))
        else $error("redirect not from option");
    a_opt_secure: assert property ($rose(rst_n) |-> secureActive == ($past(storedOptionByte[1:0]) != 2'h2))
        else $error("secure not from option");
    a_unlock_sticky: assert property (!secureActive |=> !secureActive)
        else $error("security re-engaged");
    a_block_write: assert property (memWrite && secureActive && memFromUnsecured |=> !memWriteEnable)
        else $error("blocked write passed");
    a_block_read: assert property (memRead && secureActive && memFromUnsecured |=> memReadData == 8'h00)
        else $error("blocked read passed");
endmodule // fcr_props

bind fcr_flash_cfg fcr_props u_props (
    .core_clk, .rst_n, .avs_readdata, .avs_waitrequest, .storedOptionByte, .peRequest,
    .progEraseEnable, .peRefused, .peBusy, .peDone, .timingPulse, .secureActive,
    .redirectEnable, .memRead, .memWrite, .memFromUnsecured, .memWriteEnable, .memReadData
);

// ---- verification/fcr_flash_cfg_tb.sv ----
module fcr_flash_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcr_pkg::*;

    localparam logic [63:0] GOOD_KEY = 64'h0123456789abcdef;

    logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, busFromSecureFw, busFromDebug;
    logic peRequest, blankCheckPass, progEraseEnable, peRefused, peBusy, peDone, timingPulse;
    logic secureActive, redirectEnable, memRead, memWrite, memFromUnsecured, memWriteEnable;
    logic [7:0]  avs_address, storedOptionByte, peOpPulses, memReadDataIn, memReadData, rd;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    int          nFail = 0, checksDone = 0;

    fcr_flash_cfg dut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .busFromSecureFw,
        .busFromDebug, .storedOptionByte, .storedBackdoorKey(GOOD_KEY), .peRequest,
        .peOpPulses, .blankCheckPass, .progEraseEnable, .peRefused, .peBusy, .peDone,
        .timingPulse, .secureActive, .redirectEnable, .memRead, .memWrite,
        .memFromUnsecured, .memReadDataIn, .memWriteEnable, .memReadData);

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic closeOut();
        if (nFail == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Case equality so an unknown never passes
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic timedOut(input string nm);
        nFail++;
        $display("Error %s expected answer seen none", nm);
        closeOut();
    endtask

    // Own edge first, so a release and a new request never share a step
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [7:0] rdo);
        int n;
        @(posedge core_clk);
        avs_address <= adr;
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) timedOut("waitrequest");
        rdo = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // The option byte is sampled only while reset is held
    task automatic doReset(input logic [7:0] opt);
        @(posedge core_clk);
        storedOptionByte <= opt;
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic optionCodes();
        for (int c = 0; c < 4; c++) begin
            doReset(8'hbc | c[7:0]);
            bus(1'b1, OFF_OPTION, 8'h00, rd);
            bus(1'b0, OFF_OPTION, 8'h00, rd);
            chk("option", rd, 8'h80 | c[7:0]);
            chk("secure", secureActive, c != 2);
            chk("redirect", redirectEnable, 1'b1);
            bus(1'b0, 8'h20, 8'h00, rd);
            chk("unmapped", rd, 8'h00);
        end
        doReset(8'h42);
        chk("redirect off", redirectEnable, 1'b0);
    endtask

    task automatic ratioAndPulses(input logic [7:0] cfg, input int period, input logic inRange);
        int n, p;
        doReset(8'h82);
        bus(1'b0, OFF_CLK_RATIO, 8'h00, rd);
        chk("ratio at reset", rd, 8'h00);
        peRequest <= 1'b1;
        @(posedge core_clk);
        peRequest <= 1'b0;
        @(posedge core_clk);
        chk("refused", peRefused, 1'b1);
        bus(1'b1, OFF_CLK_RATIO, cfg, rd);
        bus(1'b1, OFF_CLK_RATIO, ~cfg, rd);
        bus(1'b0, OFF_CLK_RATIO, 8'h00, rd);
        chk("ratio once", rd, cfg | 8'h80);
        chk("pe enable", progEraseEnable, 1'b1);
        bus(1'b0, OFF_STATUS, 8'h00, rd);
        chk("in range", rd[ST_RANGE_BIT], inRange);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (timingPulse !== 1'b1 && n < 600);
            if (n >= 600) timedOut("timing pulse");
        end
        chk("pulse period", n, period);
        peOpPulses <= 8'h03;
        peRequest <= 1'b1;
        @(posedge core_clk);
        peRequest <= 1'b0;
        n = 0;
        p = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (peBusy === 1'b1 && timingPulse === 1'b1) p++;
        end while (peDone !== 1'b1 && n < 2000);
        if (n >= 2000) timedOut("done");
        chk("pulses used", p, 3);
    endtask

    task automatic memGate(input logic sec);
        for (int u = 0; u < 2; u++) begin
            memWrite <= 1'b1;
            memRead <= 1'b1;
            memFromUnsecured <= u[0];
            memReadDataIn <= 8'h5a;
            repeat (2) @(posedge core_clk);
            chk("mem write", memWriteEnable, !(u[0] && sec));
            chk("mem read", memReadData, (u[0] && sec) ? 8'h00 : 8'h5a);
            memWrite <= 1'b0;
            memRead <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    task automatic keyTry(input logic [7:0] opt, input logic [63:0] k, input logic dbg,
                          input logic stay);
        int n;
        doReset(opt);
        @(posedge core_clk);
        busFromDebug <= dbg;
        busFromSecureFw <= !dbg;
        bus(1'b1, OFF_KEY_CTRL, 8'h01, rd);
        for (int i = 0; i < KEY_BYTES; i++) bus(1'b1, OFF_KEY_DATA, k[8*i+:8], rd);
        bus(1'b1, OFF_KEY_CTRL, 8'h00, rd);
        n = 0;
        do begin
            bus(1'b0, OFF_STATUS, 8'h00, rd);
            n++;
        end while (rd[ST_KEY_BUSY_BIT] !== 1'b0 && n < 40);
        if (n >= 40) timedOut("key check");
        chk("key secure", secureActive, stay);
        bus(1'b0, OFF_OPTION, 8'h00, rd);
        chk("key code", rd[1:0], stay ? 2'h3 : 2'h2);
        memGate(stay);
    endtask

    task automatic blankCheck();
        int n;
        doReset(8'h03);
        memGate(1'b1);
        blankCheckPass <= 1'b1;
        @(posedge core_clk);
        blankCheckPass <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (secureActive !== 1'b0 && n < 5);
        chk("blank check", secureActive, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        busFromSecureFw = 1'b1;
        busFromDebug = 1'b0;
        storedOptionByte = 8'h82;
        peRequest = 1'b0;
        peOpPulses = 8'h00;
        blankCheckPass = 1'b0;
        memRead = 1'b0;
        memWrite = 1'b0;
        memFromUnsecured = 1'b0;
        memReadDataIn = 8'h00;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        optionCodes();
        ratioAndPulses(8'h5f, 256, 1'b1);
        ratioAndPulses(8'h02, 3, 1'b0);
        keyTry(8'h83, GOOD_KEY ^ 64'h1, 1'b0, 1'b1);
        keyTry(8'h03, GOOD_KEY, 1'b0, 1'b1);
        keyTry(8'h83, GOOD_KEY, 1'b1, 1'b1);
        keyTry(8'h83, GOOD_KEY, 1'b0, 1'b0);
        blankCheck();
        closeOut();
    end
endmodule // fcr_flash_cfg_tb
